// file: rtl/mcu_instruction_decode_core.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// (RQ1) instruction word is fourteen bits wide
// (RQ2) sort words into byte, bit, literal classes
// (RQ3) destination zero to W, one to file
// (RQ4) file address is seven bits wide
// (RQ5) bit select picks one of eight bits
// (RQ6) literals eight bits, jump targets eleven
// (RQ7) instruction cycle is four clock periods
// (RQ8) skips and jumps take two cycles
// (RQ9) file operand always read before write
// (RQ10) clearing port still performs port read
// (RQ11) don't-care bits never change behaviour
// (RQ12) port self-modify reads pin levels
// (RQ13) fixed field positions for address, d, bit
// (RQ14) flushed cycle changes no state
module mcu_instruction_decode_core
    import idec_pkg::*;
(
    input wire logic ref_clk, // core oscillator
    input wire logic rstn, // synchronous reset, low active
    input wire logic [WORD_W-1:0] progData, // program memory word
    output logic [PC_W-1:0] progAddr, // program memory address
    output logic [FADDR_W-1:0] fileAddr, // data register file address
    output logic fileRead, // one-cycle read strobe
    input wire logic [7:0] fileRdata, // file register latch data
    input wire logic [7:0] pinLevel, // pin levels of the addressed port
    output logic fileWrite, // one-cycle write strobe
    output logic [7:0] fileWdata, // write data
    output logic [7:0] wReg, // working register
    output logic [7:0] statusReg, // status flags
    output logic [1:0] opClass, // class of executing word
    output logic flushCycle, // executing forced no-op
    output logic cycleStart // first phase pulse
);
    // ==========================================
    // phase divider
    logic [1:0] phase_q;
    logic [WORD_W-1:0] ir_q;
    logic [WORD_W-1:0] fetch_q;
    logic [PC_W-1:0] pc_q;
    logic [PC_W-1:0] stack_q [STACK_D];
    logic [2:0] sp_q;
    logic flush_q;
    logic [7:0] opnd_q;
    logic [7:0] pinSync1_q;
    logic [7:0] pinSync2_q;
    logic [7:0] aluRes;
    logic aluC, aluDc, aluZ, setsC, setsZ, bitTrue;
    logic isByte, isBit, isJump, isLit, usesFile, toFile;
    logic isGoto, isCall, isReturn, isRetfie, isRetlw, isSleep, isClrwdt;
    logic pcWrite, redirect;

    // skip forms test the result instead of keeping flags; used by write-back and checks
    function automatic logic skipForm(input logic [WORD_W-1:0] w);
        return (w[13:12] == 2'b00) && (w[11:8] == 4'hb || w[11:8] == 4'hf);
    endfunction

    // four clock periods make one instruction cycle
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            phase_q <= 2'h0;
        end else begin
            phase_q <= (phase_q == PHASES) ? 2'h0 : phase_q + 2'h1; // RQ7
        end
    end

    // ==========================================
    // decode
    always_comb begin
        isByte = (ir_q[13:12] == CLS_BYTE); // RQ2
        isBit = (ir_q[13:12] == CLS_BIT);
        isJump = (ir_q[13:12] == CLS_JUMP);
        isLit = (ir_q[13:12] == CLS_LIT);
        isGoto = isJump && ir_q[11];
        isCall = isJump && !ir_q[11];
        isRetlw = isLit && (ir_q[11:10] == 2'b01);
        isReturn = (ir_q == 14'h0008);
        isRetfie = (ir_q == 14'h0009);
        isSleep = (ir_q == 14'h0063);
        isClrwdt = (ir_q == 14'h0064);
        // byte ops with d=0 and zero nibble are control or nop, not file
        usesFile = isBit || (isByte && (ir_q[11:8] != 4'h0 || ir_q[DEST_BIT]));
        // clear-W form shares opcode with clear-f; d=0 keeps it off the file
        toFile = (isByte && ir_q[DEST_BIT]) || (isBit && !ir_q[11]); // RQ3 RQ13
        pcWrite = toFile && (ir_q[6:0] == ADDR_PCL);
        redirect = isJump || isReturn || isRetfie || isRetlw || bitTrue || pcWrite; // RQ8
    end

    alu_unit u_alu (
        .instr(ir_q),
        .wVal(wReg),
        .fVal(opnd_q),
        .carryIn(statusReg[ST_C]),
        .result(aluRes),
        .cOut(aluC),
        .dcOut(aluDc),
        .zOut(aluZ),
        .setsC(setsC),
        .setsZ(setsZ),
        .bitTrue(bitTrue)
    );

    // ==========================================
    // pins cross two flops before use
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pinSync1_q <= 8'h00;
            pinSync2_q <= 8'h00;
        end else begin
            pinSync1_q <= pinLevel;
            pinSync2_q <= pinSync1_q;
        end
    end

    // operand read happens for every file-form word, even pure writes
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            fileRead <= 1'b0;
            opnd_q <= 8'h00;
            fileAddr <= 7'h00;
        end else begin
            fileRead <= (phase_q == PH_READ - 2'h1) && usesFile && !flush_q; // RQ9 RQ10
            fileAddr <= ir_q[FADDR_W-1:0]; // RQ4 RQ13
            if (fileRead) begin
                opnd_q <= isPort(fileAddr) ? pinSync2_q : fileRdata; // RQ12
            end
        end
    end

    // write-back and W update at the last phase
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            fileWrite <= 1'b0;
            fileWdata <= 8'h00;
            wReg <= 8'h00;
            statusReg <= STATUS_RESET;
        end else begin
            fileWrite <= 1'b0;
            if (phase_q == PH_WRITE && !flush_q) begin // RQ14
                if (toFile) begin
                    fileWrite <= 1'b1;
                    fileWdata <= aluRes;
                end else if ((isByte && usesFile && !bitTrue && !skipForm(ir_q)) || isLit) begin
                    wReg <= aluRes; // RQ3
                end else if (isByte && usesFile) begin
                    wReg <= aluRes;
                end
                if (setsZ) begin
                    statusReg[ST_Z] <= aluZ;
                end
                if (setsC) begin
                    statusReg[ST_C] <= aluC;
                    statusReg[ST_DC] <= aluDc;
                end else if (isByte && (ir_q[11:8] == 4'hc || ir_q[11:8] == 4'hd)) begin
                    statusReg[ST_C] <= aluC;
                end
                if (isSleep) begin
                    statusReg[ST_PD] <= 1'b0;
                    statusReg[ST_TO] <= 1'b1;
                end
                if (isClrwdt) begin
                    statusReg[ST_PD] <= 1'b1;
                    statusReg[ST_TO] <= 1'b1;
                end
            end
        end
    end

    // ==========================================
    // fetch, program counter and stack
    // the next word is always prefetched at the last phase; a redirect
    // marks it flushed instead of refetching, which costs one whole cycle
    // limitation: the stack wraps silently after eight nested calls
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pc_q <= RESET_VECTOR;
            fetch_q <= 14'h0000;
            ir_q <= 14'h0000;
            flush_q <= 1'b1;
            sp_q <= 3'h0;
            progAddr <= RESET_VECTOR;
        end else if (phase_q == PH_WRITE) begin
            flush_q <= 1'b0;
            ir_q <= progData; // RQ1
            pc_q <= pc_q + 13'h0001;
            progAddr <= pc_q + 13'h0001;
            if (!flush_q && redirect) begin
                flush_q <= 1'b1; // RQ8 RQ14
                if (isJump) begin
                    pc_q <= {pc_q[12:11], ir_q[LIT11_W-1:0]}; // RQ6
                    progAddr <= {pc_q[12:11], ir_q[LIT11_W-1:0]};
                    if (isCall) begin
                        stack_q[sp_q] <= pc_q;
                        sp_q <= sp_q + 3'h1;
                    end
                end else if (isReturn || isRetfie || isRetlw) begin
                    pc_q <= stack_q[sp_q - 3'h1];
                    progAddr <= stack_q[sp_q - 3'h1];
                    sp_q <= sp_q - 3'h1;
                end else if (pcWrite) begin
                    pc_q <= {pc_q[12:8], aluRes};
                    progAddr <= {pc_q[12:8], aluRes};
                end
            end
        end
    end

    // status outputs
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            opClass <= 2'b00;
            flushCycle <= 1'b1;
            cycleStart <= 1'b0;
        end else begin
            opClass <= ir_q[13:12];
            flushCycle <= flush_q;
            cycleStart <= (phase_q == PHASES);
        end
    end

    // ==========================================
    // checks
    a_phase_wrap: assert property (@(posedge ref_clk) disable iff (!rstn)
        phase_q == PHASES |=> phase_q == 2'h0) else $error("phase did not wrap"); // RQ7
    a_cycle_four: assert property (@(posedge ref_clk) disable iff (!rstn)
        cycleStart |=> !cycleStart [*3] ##1 cycleStart) else $error("cycle not 4"); // RQ7
    a_read_first: assert property (@(posedge ref_clk) disable iff (!rstn)
        fileWrite |-> $past(fileRead, 3)) else $error("write without read"); // RQ9
    a_flush_quiet: assert property (@(posedge ref_clk) disable iff (!rstn)
        flush_q && phase_q == PH_WRITE |=> !fileWrite && $stable(wReg))
        else $error("flush changed state"); // RQ14
    a_jump_two: assert property (@(posedge ref_clk) disable iff (!rstn)
        phase_q == PH_WRITE && !flush_q && isJump |=> flush_q) else $error("no nop"); // RQ8
    a_dest_w: assert property (@(posedge ref_clk) disable iff (!rstn)
        phase_q == PH_WRITE && !flush_q && isByte && !ir_q[DEST_BIT] |=> !fileWrite)
        else $error("d=0 wrote file"); // RQ3
    a_addr_field: assert property (@(posedge ref_clk) disable iff (!rstn)
        fileRead |-> fileAddr == ir_q[6:0]) else $error("bad address"); // RQ4
    a_port_pins: assert property (@(posedge ref_clk) disable iff (!rstn)
        fileRead && isPort(fileAddr) |=> opnd_q == $past(pinSync2_q))
        else $error("port latch used"); // RQ12
    a_clr_reads: assert property (@(posedge ref_clk) disable iff (!rstn)
        phase_q == 2'h0 && !flush_q && isByte && ir_q[11:7] == 5'h03 |=> fileRead)
        else $error("clear skipped read"); // RQ10

    // strobe placement inside the instruction cycle
    a_read_phase: assert property (@(posedge ref_clk) disable iff (!rstn)
        fileRead |-> phase_q == PH_READ) else $error("read strobe off phase"); // RQ9
    a_write_next: assert property (@(posedge ref_clk) disable iff (!rstn)
        fileWrite |-> $past(phase_q) == PH_WRITE) else $error("write strobe off phase"); // RQ9

    // two-cycle forms: skips, calls, returns and gotos
    a_skip_two: assert property (@(posedge ref_clk) disable iff (!rstn)
        phase_q == PH_WRITE && !flush_q && bitTrue |=> flush_q) else $error("skip no nop"); // RQ8
    a_call_push: assert property (@(posedge ref_clk) disable iff (!rstn)
        phase_q == PH_WRITE && !flush_q && isCall |=> sp_q == $past(sp_q) + 3'h1)
        else $error("call did not push"); // RQ8
    a_ret_pop: assert property (@(posedge ref_clk) disable iff (!rstn)
        phase_q == PH_WRITE && !flush_q && (isReturn || isRetfie || isRetlw)
        |=> sp_q == $past(sp_q) - 3'h1) else $error("return did not pop"); // RQ8
    a_goto_target: assert property (@(posedge ref_clk) disable iff (!rstn)
        phase_q == PH_WRITE && !flush_q && isGoto
        |=> progAddr == {$past(pc_q[12:11]), $past(ir_q[10:0])}) else $error("bad target"); // RQ6

    // the flushed cycle must stay silent on the file and the flags
    a_flush_noread: assert property (@(posedge ref_clk) disable iff (!rstn)
        flush_q && phase_q == 2'h0 |=> !fileRead) else $error("flush read file"); // RQ14
    a_status_flush: assert property (@(posedge ref_clk) disable iff (!rstn)
        flush_q && phase_q == PH_WRITE |=> $stable(statusReg))
        else $error("flush changed status"); // RQ14

    // results land where the class says
    a_lit_w: assert property (@(posedge ref_clk) disable iff (!rstn)
        phase_q == PH_WRITE && !flush_q && isLit |=> wReg == $past(aluRes))
        else $error("literal missed W"); // RQ6
    a_bit_only: assert property (@(posedge ref_clk) disable iff (!rstn)
        phase_q == PH_WRITE && !flush_q && isBit && !ir_q[11]
        |=> fileWrite && $countones(fileWdata ^ $past(opnd_q)) <= 1) else $error("bit op"); // RQ5
    a_skip_status: assert property (@(posedge ref_clk) disable iff (!rstn)
        phase_q == PH_WRITE && !flush_q && skipForm(ir_q) |=> $stable(statusReg[ST_Z]))
        else $error("skip form touched zero"); // RQ8
    a_sleep_pd: assert property (@(posedge ref_clk) disable iff (!rstn)
        phase_q == PH_WRITE && !flush_q && isSleep |=> !statusReg[ST_PD])
        else $error("sleep kept powerdown flag"); // RQ8
    a_class_out: assert property (@(posedge ref_clk) disable iff (!rstn)
        rstn |=> opClass == $past(ir_q[13:12])) else $error("class output stale"); // RQ2

    // main scenarios
    c_skip: cover property (@(posedge ref_clk) bitTrue && phase_q == PH_WRITE && !flush_q);
    c_return: cover property (@(posedge ref_clk) isReturn && phase_q == PH_WRITE && !flush_q);
    c_port_read: cover property (@(posedge ref_clk) fileRead && isPort(fileAddr));
    c_call: cover property (@(posedge ref_clk) isCall && phase_q == PH_WRITE && !flush_q);
    c_write: cover property (@(posedge ref_clk) fileWrite);
endmodule
`default_nettype wire

// file: rtl/idec_pkg.sv
package idec_pkg;
    // instruction word layout
    localparam int WORD_W = 14;
    localparam int FADDR_W = 7;
    localparam int DEST_BIT = 7;
    localparam int BSEL_LO = 7;
    localparam int BSEL_HI = 9;
    localparam int LIT8_W = 8;
    localparam int LIT11_W = 11;
    localparam int PC_W = 13;
    localparam int STACK_D = 8;
    // instruction cycle phases
    localparam logic [1:0] PHASES = 2'h3;
    localparam logic [1:0] PH_READ = 2'h1;
    localparam logic [1:0] PH_WRITE = 2'h3;
    // file register addresses the decoder must know
    localparam logic [6:0] ADDR_INDF = 7'h00;
    localparam logic [6:0] ADDR_PCL = 7'h02;
    localparam logic [6:0] ADDR_STATUS = 7'h03;
    localparam logic [6:0] ADDR_PORTA = 7'h05;
    localparam logic [6:0] ADDR_PORTE = 7'h09;
    // status bit positions
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_PD = 3;
    localparam int ST_TO = 4;
    localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
    localparam logic [7:0] STATUS_RESET = 8'h18;

    typedef enum logic [1:0] {
        CLS_BYTE = 2'b00,
        CLS_BIT = 2'b01,
        CLS_JUMP = 2'b10,
        CLS_LIT = 2'b11
    } op_class_e;

    // port addresses read pin levels, not latches
    function automatic logic isPort(input logic [6:0] a);
        return (a >= ADDR_PORTA) && (a <= ADDR_PORTE);
    endfunction
endpackage

// file: rtl/alu_unit.sv
`timescale 1ns/100ps
`default_nettype none
module alu_unit
    import idec_pkg::*;
(
    input wire logic [WORD_W-1:0] instr, // decoded word
    input wire logic [7:0] wVal, // working register
    input wire logic [7:0] fVal, // operand read from file
    input wire logic carryIn, // status carry
    output logic [7:0] result, // operation result
    output logic cOut, // new carry
    output logic dcOut, // new digit carry
    output logic zOut, // result is zero
    output logic setsC, // carry/dc updated
    output logic setsZ, // zero flag updated
    output logic bitTrue // tested bit condition met
);
    logic [8:0] sum;
    logic [4:0] half;
    logic [7:0] mask;
    logic [7:0] lit;

    // one combinational datapath for all three classes
    always_comb begin
        sum = 9'h000;
        half = 5'h00;
        lit = instr[7:0];
        mask = 8'h01 << instr[BSEL_HI:BSEL_LO]; // RQ5
        result = fVal;
        setsC = 1'b0;
        setsZ = 1'b0;
        cOut = carryIn;
        dcOut = 1'b0;
        bitTrue = 1'b0;
        if (instr[13:12] == 2'b00) begin
            setsZ = 1'b1;
            case (instr[11:8])
                4'h0: begin
                    result = wVal;
                    setsZ = 1'b0;
                end
                4'h1: result = 8'h00;
                4'h2: begin
                    sum = {1'b0, fVal} + {1'b0, ~wVal} + 9'h001;
                    half = {1'b0, fVal[3:0]} + {1'b0, ~wVal[3:0]} + 5'h01;
                    result = sum[7:0];
                    setsC = 1'b1;
                end
                4'h3, 4'hb: result = fVal - 8'h01;
                4'h4: result = fVal | wVal;
                4'h5: result = fVal & wVal;
                4'h6: result = fVal ^ wVal;
                4'h7: begin
                    sum = {1'b0, fVal} + {1'b0, wVal};
                    half = {1'b0, fVal[3:0]} + {1'b0, wVal[3:0]};
                    result = sum[7:0];
                    setsC = 1'b1;
                end
                4'h8: result = fVal;
                4'h9: result = ~fVal;
                4'ha, 4'hf: result = fVal + 8'h01;
                4'hc: begin
                    result = {carryIn, fVal[7:1]};
                    cOut = fVal[0];
                    setsZ = 1'b0;
                end
                4'hd: begin
                    result = {fVal[6:0], carryIn};
                    cOut = fVal[7];
                    setsZ = 1'b0;
                end
                4'he: begin
                    result = {fVal[3:0], fVal[7:4]};
                    setsZ = 1'b0;
                end
                default: result = fVal;
            endcase
            // skip forms leave status alone
            if (instr[11:8] == 4'hb || instr[11:8] == 4'hf) begin
                setsZ = 1'b0;
                bitTrue = (result == 8'h00);
            end
        end else if (instr[13:12] == 2'b01) begin
            case (instr[11:10])
                2'b00: result = fVal & ~mask;
                2'b01: result = fVal | mask;
                2'b10: bitTrue = ((fVal & mask) == 8'h00);
                default: bitTrue = ((fVal & mask) != 8'h00);
            endcase
        end else if (instr[13:12] == 2'b11) begin
            setsZ = 1'b1;
            // x bits in literal opcodes ignored by casez
            casez (instr[11:8]) // RQ11
                4'b00??, 4'b01??: begin
                    result = lit; // RQ6
                    setsZ = 1'b0;
                end
                4'b1000: result = lit | wVal;
                4'b1001: result = lit & wVal;
                4'b1010: result = lit ^ wVal;
                4'b110?: begin
                    sum = {1'b0, lit} + {1'b0, ~wVal} + 9'h001;
                    half = {1'b0, lit[3:0]} + {1'b0, ~wVal[3:0]} + 5'h01;
                    result = sum[7:0];
                    setsC = 1'b1;
                end
                4'b111?: begin
                    sum = {1'b0, lit} + {1'b0, wVal};
                    half = {1'b0, lit[3:0]} + {1'b0, wVal[3:0]};
                    result = sum[7:0];
                    setsC = 1'b1;
                end
                default: result = lit;
            endcase
        end
        if (setsC) begin
            cOut = sum[8];
        end
        dcOut = half[4];
        zOut = (result == 8'h00);
    end
endmodule
`default_nettype wire

// file: sim/prog_data_model.sv
`timescale 1ns/100ps
`default_nettype none
// =====================================================================
// program memory and data register file seen by the core
module prog_data_model
    import idec_pkg::*;
(
    input wire logic ref_clk, // core clock
    input wire logic [PC_W-1:0] progAddr, // fetch address
    output logic [WORD_W-1:0] progData, // fetched word
    input wire logic [FADDR_W-1:0] fileAddr, // file address
    input wire logic fileRead, // read strobe
    output logic [7:0] fileRdata, // read data
    input wire logic fileWrite, // write strobe
    input wire logic [7:0] fileWdata // write data
);
    logic [WORD_W-1:0] rom [0:63];
    logic [7:0] ram [0:127];
    int rdCnt [0:127];
    int wrCnt [0:127];
    logic rdWin_q = 1'b0;
    logic [7:0] junk_q = 8'h5A;

    // registered fetch; the word has settled long before the phase 3 sample
    always @(posedge ref_clk) begin
        progData <= rom[progAddr[5:0]];
        rdWin_q <= fileRead;
        junk_q <= ~junk_q;
        if (fileRead) begin
            rdCnt[fileAddr]++;
        end
        if (fileWrite) begin
            ram[fileAddr] <= fileWdata;
            wrCnt[fileAddr]++;
        end
    end

    // data valid only in the read window; a toggling pattern elsewhere exposes a late capture
    always_comb fileRdata = (fileRead || rdWin_q) ? ram[fileAddr] : junk_q;
endmodule
`default_nettype wire

// file: sim/mcu_instruction_decode_core_test.sv
`timescale 1ns/100ps
`default_nettype none
module mcu_instruction_decode_core_test
    import idec_pkg::*;
;
    logic ref_clk;
    logic rstn;
    logic [7:0] pinLevel;
    logic [WORD_W-1:0] progData;
    logic [PC_W-1:0] progAddr;
    logic [FADDR_W-1:0] fileAddr;
    logic fileRead;
    logic [7:0] fileRdata;
    logic fileWrite;
    logic [7:0] fileWdata;
    logic [7:0] wReg;
    logic [7:0] statusReg;
    logic cycleStart;
    logic flushCycle;
    int errorCnt = 0;
    int comparisons = 0;
    int cycles = 0;
    int gap = 0;
    int seed;

    mcu_instruction_decode_core i_dut (.ref_clk(ref_clk), .rstn(rstn), .progData(progData),
        .progAddr(progAddr), .fileAddr(fileAddr), .fileRead(fileRead), .fileRdata(fileRdata),
        .pinLevel(pinLevel), .fileWrite(fileWrite), .fileWdata(fileWdata), .wReg(wReg),
        .statusReg(statusReg), .opClass(), .flushCycle(flushCycle), .cycleStart(cycleStart));

    prog_data_model i_mem (.ref_clk(ref_clk), .progAddr(progAddr), .progData(progData),
        .fileAddr(fileAddr), .fileRead(fileRead), .fileRdata(fileRdata),
        .fileWrite(fileWrite), .fileWdata(fileWdata));

    // =====================================================================
    // clock, timeout and instruction cycle spacing
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // the gap is measured edge to edge, so a phase counter off by one shows at once
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errorCnt++;
            endSim();
        end
        if (!rstn) begin
            gap = 0;
        end else if (cycleStart === 1'b1) begin
            if (gap != 0) check_count("cycleGap", 4, gap);
            gap = 1;
        end else if (gap != 0) begin
            gap++;
        end
    end

    // =====================================================================
    // compare tasks and expectations
    task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            errorCnt++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_count(input string name, input int exp, input int got);
        comparisons++;
        if (got != exp) begin
            errorCnt++;
            $display("mismatch %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic endSim();
        if (errorCnt == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    function automatic logic [13:0] enc(input logic [13:0] op, input logic [2:0] bs,
        input logic [6:0] fa);
        return op | {4'h0, bs, fa};
    endfunction

    // last carry-setting op is the d=0 add; the final port clear leaves zero set
    function automatic logic [7:0] exp_status(input logic [7:0] a, input logic [7:0] c);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, c};
        h = {1'b0, a[3:0]} + {1'b0, c[3:0]};
        return STATUS_RESET | {5'h00, 1'b1, h[4], s[8]};
    endfunction

    // =====================================================================
    // one program run: load, reset, execute, inspect
    task automatic run_prog(input int iter);
        logic [7:0] k1, k2, pin, f3Init, sum1;
        logic [6:0] f1, f2, f3;
        logic [2:0] b;
        logic [13:0] prog [0:17];
        int n;
        k1 = $random(seed);
        k2 = $random(seed);
        pin = $random(seed);
        f3Init = $random(seed);
        b = $random(seed);
        f1 = 7'h20 | 7'($unsigned($random(seed)) % 32);
        f2 = 7'h40 | 7'($unsigned($random(seed)) % 32);
        f3 = 7'h60 | 7'($unsigned($random(seed)) % 32);
        // corners: full carry and top address, then zero literal and lowest bit
        if (iter == 0) begin
            k1 = 8'hFF;
            k2 = 8'h01;
            b = 3'd7;
            f3 = 7'h7F;
        end else if (iter == 1) begin
            k1 = 8'h00;
            b = 3'd0;
            f1 = 7'h20;
        end
        sum1 = k1 + k2;
        prog = '{14'h0000, 14'h3300 | {6'h00, k1}, enc(14'h0080, 3'd0, f1),
            14'h3000 | {6'h00, k2}, enc(14'h0780, 3'd0, f1), enc(14'h0700, 3'd0, f1),
            enc(14'h1400, b, f1), enc(14'h1C00, b, f1), enc(14'h0180, 3'd0, f3),
            enc(14'h1000, b, f1), enc(14'h1800, b, f1), enc(14'h0A80, 3'd0, f3),
            14'h0806, enc(14'h0080, 3'd0, f2), 14'h0186, 14'h2811,
            enc(14'h0180, 3'd0, f3), 14'h2811};
        @(posedge ref_clk);
        rstn <= 1'b0;
        pinLevel <= pin;
        for (n = 0; n < 64; n++) i_mem.rom[n] = (n < 18) ? prog[n] : 14'h0000;
        for (n = 0; n < 128; n++) begin
            i_mem.ram[n] = $random(seed);
            i_mem.rdCnt[n] = 0;
            i_mem.wrCnt[n] = 0;
        end
        i_mem.ram[f3] = f3Init;
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        check_count("flushAfterReset", 1, int'(flushCycle === 1'b1));
        n = 0;
        while (progAddr !== 13'h0011 && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
        // a program that never reaches its final loop is a failure
        if (n == 400) errorCnt++;
        repeat (12) @(posedge ref_clk);
        check_byte("wReg", pin, wReg);
        check_byte("statusReg", exp_status(sum1, k2), statusReg);
        check_byte("fileF1", sum1 & ~(8'h01 << b), i_mem.ram[f1]);
        check_byte("fileF2", pin, i_mem.ram[f2]);
        check_byte("portReg", 8'h00, i_mem.ram[6]);
        check_byte("fileF3", f3Init, i_mem.ram[f3]);
        check_count("readsF2", 1, i_mem.rdCnt[f2]);
        check_count("readsPort", 2, i_mem.rdCnt[6]);
        check_count("writesF1", 4, i_mem.wrCnt[f1]);
        check_count("touchF3", 0, i_mem.rdCnt[f3] + i_mem.wrCnt[f3]);
    endtask

    // =====================================================================
    // main sequence: two corner runs, then random runs, each after a fresh reset
    initial begin
        seed = 12;
        rstn = 1'b0;
        pinLevel = 8'h00;
        for (int i = 0; i < 4; i++) run_prog(i);
        endSim();
    end
endmodule
`default_nettype wire
